// ===== bench/spp_master_model.sv
/*
  Master model of the processor port: drives the pins on the link clock.
  Assumes the port samples pins on the rising link edge; records its answers.
*/
`timescale 1ns/1ns
module spp_master_model (
  input  wire logic                       link_clk_in,
  input  wire logic [spp_pkg::DATA_W-1:0] dq_in,
  input  wire logic                       rdy_in,
  input  wire logic                       flag_in,
  input  wire logic                       dma_in,
  output spp_pkg::spp_mux_pins_s          mux_out,
  output spp_pkg::spp_fifo_pins_s         fifo_out,
  output logic      [spp_pkg::DATA_W-1:0] dq_out
);
  logic [7:0]  rt;
  logic [15:0] tr [8];
  // Idle pins; a released bus shows the inverse of its last value
  initial begin
    mux_out = '1;
    fifo_out = '1;
    dq_out = 16'h0000;
  end
  // Pins change just after the shared rising edge
  task automatic step();
    @(posedge link_clk_in);
    #2;
  endtask : step
  // Muxed transfer of n words from w0 upward; rt holds ready after each edge
  task automatic mux_op(input logic wr, input logic [3:0] a, input int n,
                        input logic [15:0] w0);
    step();
    mux_out.ce_n = 1'b0;
    mux_out.address_valid_n = 1'b0;
    dq_out = {12'h000, a};
    step();
    mux_out.address_valid_n = 1'b1;
    mux_out.we_n = !wr;
    mux_out.oe_n = wr;
    dq_out = wr ? w0 : ~dq_out;
    for (int k = 0; k < 8; k++) begin
      step();
      rt[k] = rdy_in;
      tr[k] = dq_in;
      if (wr && k >= 2 && k <= n) dq_out = w0 + 16'(k - 1);
      if (wr && k == n + 1) begin
        mux_out.we_n = 1'b1;
        dq_out = ~dq_out;
      end
    end
    mux_out = '1;
    dq_out = ~dq_out;
    step();
  endtask : mux_op
  // FIFO transfer of n words on thread s; pe marks the last word or a ZLP
  task automatic fifo_op(input logic wr, input logic [1:0] s, input int n,
                         input logic [15:0] w0, input logic pe);
    step();
    fifo_out.fifo_chip_select_n = 1'b0;
    fifo_out.fifo_select_lines = s;
    fifo_out.fifo_output_enable_n = wr;
    step();
    fifo_out.fifo_write_strobe_n = !wr || n == 0;
    fifo_out.fifo_read_strobe_n = wr || n == 0;
    fifo_out.packet_end_n = !(pe && n <= 1);
    dq_out = wr ? w0 : ~dq_out;
    for (int k = 0; k < 8; k++) begin
      step();
      rt[k] = flag_in;
      tr[k] = dq_in;
      if (k >= n - 1) begin
        fifo_out.fifo_write_strobe_n = 1'b1;
        fifo_out.fifo_read_strobe_n = 1'b1;
        fifo_out.packet_end_n = 1'b1;
        dq_out = ~dq_out;
      end else if (wr) begin
        dq_out = w0 + 16'(k + 1);
        fifo_out.packet_end_n = !(pe && k == n - 2);
      end
    end
    fifo_out = '1;
    step();
  endtask : fifo_op
  // Socket switch to thread s; c counts edges until thread ready
  task automatic sw_op(input logic [1:0] s, output int c);
    step();
    fifo_out.fifo_select_lines = s;
    fifo_out.socket_switch_n = 1'b0;
    step();
    fifo_out.socket_switch_n = 1'b1;
    c = 1;
    while (dma_in !== 1'b1 && c < 80) begin
      step();
      c++;
    end
  endtask : sw_op
endmodule : spp_master_model

// ===== bench/tb_sync_processor_port.sv
/*
  Self-checking bench of the processor port, muxed and FIFO modes.
  Assumes spp_master_model drives the pins; link clock 48 ns, core 40 ns.
*/
`timescale 1ns/1ns
module tb_sync_processor_port;
  logic                    mclk_in, srst_in, link_clk_in;
  logic                    busy, pkt, zlp, dq_oe_n, rdy, flag, dma;
  logic [15:0]             dq_o, dq_d;
  spp_pkg::spp_cfg_s       cfg;
  spp_pkg::spp_mux_pins_s  mux;
  spp_pkg::spp_fifo_pins_s fifo;
  int                      n_errors = 0, n_checks = 0, n_pkt = 0, n_zlp = 0, c;
  spp_port_top dut (.mclk_in(mclk_in), .srst_in(srst_in), .link_clk_in(link_clk_in),
    .cfg_in(cfg), .cfg_busy_out(busy), .pkt_commit_out(pkt), .zlp_out(zlp),
    .mux_pins_in(mux), .fifo_pins_in(fifo), .dq_in(dq_d), .dq_out(dq_o),
    .dq_oe_n_out(dq_oe_n), .rdy_out(rdy), .flag_out(flag), .dma_a_out(dma));
  spp_master_model m (.link_clk_in(link_clk_in), .dq_in(dq_o), .rdy_in(rdy),
    .flag_in(flag), .dma_in(dma), .mux_out(mux), .fifo_out(fifo), .dq_out(dq_d));
  // Core and link clocks, unrelated in phase
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #24 link_clk_in = ~link_clk_in;
  end
  // Count packet pulses
  always @(posedge mclk_in) begin
    if (pkt === 1'b1) n_pkt++;
    if (zlp === 1'b1) n_zlp++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Apply a configuration and wait for its crossing to finish
  task automatic set_cfg(input logic md, input logic sh, input logic bt, input logic bu);
    @(posedge mclk_in);
    #2;
    cfg = spp_pkg::CFG_RST;
    cfg.muxed_addr_data_mode = md;
    cfg.short_latency = sh;
    cfg.boot_active = bt;
    cfg.burst_mode = bu;
    cfg.flag_kind = spp_pkg::FLAG_PARTIAL;
    cfg.producer_mask = 4'h2;
    repeat (2) @(posedge mclk_in);
    c = 0;
    while (busy !== 1'b0 && c < 60) begin
      @(posedge mclk_in);
      c++;
    end
    repeat (4) @(posedge mclk_in);
  endtask : set_cfg
  task automatic t_mux_single();
    set_cfg(1'b1, 1'b0, 1'b0, 1'b0);
    m.mux_op(1'b1, 4'h5, 1, 16'ha1b2);
    chk(16'(m.rt), 16'h000e);
    m.mux_op(1'b0, 4'h5, 1, 16'h0000);
    chk(16'(m.rt), 16'h0002);
    chk(m.tr[1], 16'ha1b2);
    chk(m.tr[7], 16'ha1b2);
  endtask : t_mux_single
  task automatic t_latency();
    set_cfg(1'b1, 1'b1, 1'b1, 1'b0);
    m.mux_op(1'b0, 4'h5, 1, 16'h0000);
    chk(16'(m.rt), 16'h0002);
    set_cfg(1'b1, 1'b1, 1'b0, 1'b0);
    m.mux_op(1'b0, 4'h5, 1, 16'h0000);
    chk(16'(m.rt), 16'h0001);
    chk(m.tr[0], 16'ha1b2);
  endtask : t_latency
  task automatic t_mux_burst();
    set_cfg(1'b1, 1'b0, 1'b0, 1'b1);
    m.mux_op(1'b1, 4'h8, 4, 16'h1000);
    chk(16'(m.rt), 16'h007e);
    m.mux_op(1'b0, 4'h8, 4, 16'h0000);
    chk(16'(m.rt), 16'h001e);
    for (int j = 0; j < 4; j++) chk(m.tr[1+j], 16'h1000 + 16'(j));
    chk(m.tr[7], 16'h1003);
  endtask : t_mux_burst
  task automatic t_fifo();
    set_cfg(1'b0, 1'b0, 1'b0, 1'b0);
    m.fifo_op(1'b1, 2'h1, 4, 16'hc000, 1'b1);
    chk(16'(m.rt[5:4]), 16'h0002);
    repeat (10) @(posedge mclk_in);
    chk(16'(n_pkt), 16'h0001);
    m.fifo_op(1'b0, 2'h1, 4, 16'h0000, 1'b0);
    for (int j = 0; j < 4; j++) chk(m.tr[1+j], 16'hc000 + 16'(j));
    chk(m.tr[7], 16'hc003);
    chk(16'(dq_oe_n), 16'h0001);
    m.fifo_op(1'b1, 2'h1, 0, 16'h0000, 1'b1);
    repeat (10) @(posedge mclk_in);
    chk(16'(n_zlp), 16'h0001);
    chk(16'(n_pkt), 16'h0001);
    m.sw_op(2'h1, c);
    chk(16'(c >= 2 && c <= 68), 16'h0001);
  endtask : t_fifo
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // Reset, then the scenarios in turn
  initial begin
    srst_in = 1'b1;
    cfg = spp_pkg::CFG_RST;
    repeat (12) @(posedge mclk_in);
    #2;
    srst_in = 1'b0;
    repeat (6) @(posedge link_clk_in);
    t_mux_single();
    t_latency();
    t_mux_burst();
    t_fifo();
    wrap_up();
  end
  // Watchdog well beyond the expected run
  initial begin
    #150000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_sync_processor_port

// ===== hw/spp_pkg.sv
/*
  Shared constants, types and pin bundles of the synchronous processor port.
  Assumes a link clock from the external master and an unrelated core clock.
*/
package spp_pkg;
  localparam int DATA_W = 16;
  localparam int MUX_AW = 4;
  localparam int THREADS = 4;
  localparam int THR_W = 2;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;

  // Thread store depth and partial-fill level
  localparam logic [CNT_W-1:0] FIFO_DEPTH    = 4'h8;
  localparam logic [CNT_W-1:0] PARTIAL_LEVEL = 4'h4;
  // Burst of four words; write tail of two edges
  localparam logic [1:0]       BURST_LAST    = 2'h3;
  localparam logic [1:0]       WR_TAIL_LAST  = 2'h1;
  // Socket switch delay, inside the 2 to 68 cycle window
  localparam logic [6:0]       SSD_CYCLES    = 7'h04;
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST     = 16'h0000;
  localparam logic [MUX_AW-1:0] ADDR_RST     = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RWAIT = 3'b001,
    ST_RDATA = 3'b010,
    ST_RHOLD = 3'b011,
    ST_WWAIT = 3'b100,
    ST_WDATA = 3'b101,
    ST_WTAIL = 3'b110
  } spp_mux_state_e;

  typedef enum logic [1:0] {
    FLAG_EMPTY   = 2'b00,
    FLAG_FULL    = 2'b01,
    FLAG_PARTIAL = 2'b10
  } spp_flag_kind_e;

  typedef struct packed {
    logic             muxed_addr_data_mode;
    logic             short_latency;
    logic             boot_active;
    logic             burst_mode;
    spp_flag_kind_e   flag_kind;
    logic             flag_dedicated;
    logic [THR_W-1:0] flag_thread;
    logic [THREADS-1:0] producer_mask;
  } spp_cfg_s;

  localparam spp_cfg_s CFG_RST = '0;

  typedef struct packed {
    logic ce_n;
    logic address_valid_n;
    logic oe_n;
    logic we_n;
  } spp_mux_pins_s;

  typedef struct packed {
    logic             fifo_chip_select_n;
    logic             fifo_output_enable_n;
    logic             fifo_read_strobe_n;
    logic             fifo_write_strobe_n;
    logic             packet_end_n;
    logic             socket_switch_n;
    logic [THR_W-1:0] fifo_select_lines;
  } spp_fifo_pins_s;
endpackage : spp_pkg

// ===== hw/spp_port_top.sv
/*
  Synchronous processor port: multiplexed address/data mode and slave FIFO mode.
  Assumes the master drives all pins on the link clock; the link clock runs while
  srst_in is held; configuration arrives on the core clock.
*/
`timescale 1ns/1ns
module spp_port_top (
  input  wire logic                       mclk_in,
  input  wire logic                       srst_in,
  input  wire logic                       link_clk_in,
  input  wire spp_pkg::spp_cfg_s          cfg_in,
  output logic                            cfg_busy_out,
  output logic                            pkt_commit_out,
  output logic                            zlp_out,
  input  wire spp_pkg::spp_mux_pins_s     mux_pins_in,
  input  wire spp_pkg::spp_fifo_pins_s    fifo_pins_in,
  input  wire logic [spp_pkg::DATA_W-1:0] dq_in,
  output logic      [spp_pkg::DATA_W-1:0] dq_out,
  output logic                            dq_oe_n_out,
  output logic                            rdy_out,
  output logic                            flag_out,
  output logic                            dma_a_out
);
  localparam int DW = spp_pkg::DATA_W;
  localparam int NT = spp_pkg::THREADS;

  // Core-side configuration hold and handshake
  spp_pkg::spp_cfg_s cfg_hold_reg;
  logic              req_reg;
  logic              busy_reg;
  logic              ack_core;
  logic [1:0]        ev_core;
  logic [1:0]        ev_prev_reg;

  // Link-side state
  logic              lrst;
  logic              req_link;
  logic              ack_reg;
  spp_pkg::spp_cfg_s cfg_l;
  spp_pkg::spp_mux_state_e st_reg;
  logic [spp_pkg::MUX_AW-1:0] addr_reg;
  logic [1:0]        beat_reg;
  logic [1:0]        tail_reg;
  logic [DW-1:0]     rd_q_reg;
  logic [DW-1:0]     mux_mem [2**spp_pkg::MUX_AW];

  assign cfg_busy_out = busy_reg;

  // Link reset and configuration request into the link domain
  spp_sync3 #(.W(2)) u_sync_link (
    .clk_in (link_clk_in),
    .d_in   ({srst_in, req_reg}),
    .q_out  ({lrst, req_link})
  );

  // Acknowledge and packet event toggles into the core domain
  logic       pkt_tog_reg;
  logic       zlp_tog_reg;
  spp_sync3 #(.W(3)) u_sync_core (
    .clk_in (mclk_in),
    .d_in   ({ack_reg, zlp_tog_reg, pkt_tog_reg}),
    .q_out  ({ack_core, ev_core})
  );

  // Core: take a new configuration when idle, wait for the link echo
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cfg_hold_reg <= spp_pkg::CFG_RST;
      req_reg      <= 1'b0;
      busy_reg     <= 1'b0;
    end else if (!busy_reg && cfg_in != cfg_hold_reg) begin
      cfg_hold_reg <= cfg_in;
      req_reg      <= ~req_reg;
      busy_reg     <= 1'b1;
    end else if (busy_reg && ack_core == req_reg) begin
      busy_reg <= 1'b0;
    end
  end

  // Core: packet commit and zero-length pulses
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ev_prev_reg    <= 2'h0;
      pkt_commit_out <= 1'b0;
      zlp_out        <= 1'b0;
    end else begin
      ev_prev_reg    <= ev_core;
      pkt_commit_out <= ev_core[0] ^ ev_prev_reg[0];
      zlp_out        <= ev_core[1] ^ ev_prev_reg[1];
    end
  end

  // Link: capture held configuration when the request toggles
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      cfg_l   <= spp_pkg::CFG_RST;
      ack_reg <= 1'b0;
    end else if (req_link != ack_reg) begin
      cfg_l   <= cfg_hold_reg;
      ack_reg <= req_link;
    end
  end

  // Multiplexed mode decode
  logic mux_mode;
  logic short_lat;
  logic burst;
  logic bus_rel_rd;
  logic rd_start;
  logic wr_start;
  logic cap_word;
  logic cap_last;
  logic rd_last;

  assign mux_mode   = cfg_l.muxed_addr_data_mode;
  assign short_lat  = cfg_l.short_latency && !cfg_l.boot_active;
  assign burst      = cfg_l.burst_mode;
  assign bus_rel_rd = mux_pins_in.oe_n || mux_pins_in.ce_n;
  assign rd_start   = mux_mode && st_reg == spp_pkg::ST_IDLE && !bus_rel_rd
                      && mux_pins_in.address_valid_n;
  assign wr_start   = mux_mode && st_reg == spp_pkg::ST_IDLE && !mux_pins_in.ce_n
                      && !mux_pins_in.we_n && mux_pins_in.oe_n
                      && mux_pins_in.address_valid_n;
  assign cap_word   = st_reg == spp_pkg::ST_WDATA && !mux_pins_in.we_n
                      && !mux_pins_in.ce_n;
  assign rd_last    = !burst || beat_reg == spp_pkg::BURST_LAST;
  assign cap_last   = cap_word && rd_last;
  assign rdy_out    = mux_mode && (st_reg == spp_pkg::ST_RDATA
                      || st_reg == spp_pkg::ST_WDATA || st_reg == spp_pkg::ST_WTAIL);

  // Multiplexed word store, written on each sampled data edge
  always_ff @(posedge link_clk_in) begin
    if (cap_word) begin
      mux_mem[addr_reg] <= dq_in;
    end
  end

  // Multiplexed transfer sequencer
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      st_reg   <= spp_pkg::ST_IDLE;
      addr_reg <= spp_pkg::ADDR_RST;
      beat_reg <= 2'h0;
      tail_reg <= 2'h0;
      rd_q_reg <= spp_pkg::DATA_RST;
    end else begin
      case (st_reg)
        spp_pkg::ST_IDLE: begin
          beat_reg <= 2'h0;
          tail_reg <= 2'h0;
          if (mux_mode && !mux_pins_in.ce_n && !mux_pins_in.address_valid_n) begin
            addr_reg <= dq_in[spp_pkg::MUX_AW-1:0];
          end else if (rd_start) begin
            if (short_lat) begin
              rd_q_reg <= mux_mem[addr_reg];
              st_reg   <= spp_pkg::ST_RDATA;
            end else begin
              st_reg <= spp_pkg::ST_RWAIT;
            end
          end else if (wr_start) begin
            st_reg <= short_lat ? spp_pkg::ST_WDATA : spp_pkg::ST_WWAIT;
          end
        end
        spp_pkg::ST_RWAIT: begin
          if (bus_rel_rd) begin
            st_reg <= spp_pkg::ST_IDLE;
          end else begin
            rd_q_reg <= mux_mem[addr_reg];
            st_reg   <= spp_pkg::ST_RDATA;
          end
        end
        spp_pkg::ST_RDATA: begin
          if (bus_rel_rd) begin
            st_reg <= spp_pkg::ST_IDLE;
          end else if (rd_last) begin
            st_reg <= spp_pkg::ST_RHOLD;
          end else begin
            beat_reg <= beat_reg + 2'h1;
            addr_reg <= addr_reg + 4'h1;
            rd_q_reg <= mux_mem[addr_reg + 4'h1];
          end
        end
        spp_pkg::ST_RHOLD: begin
          if (bus_rel_rd) begin
            st_reg <= spp_pkg::ST_IDLE;
          end
        end
        spp_pkg::ST_WWAIT: begin
          if (mux_pins_in.we_n || mux_pins_in.ce_n) begin
            st_reg <= spp_pkg::ST_IDLE;
          end else begin
            st_reg <= spp_pkg::ST_WDATA;
          end
        end
        spp_pkg::ST_WDATA: begin
          if (!cap_word) begin
            st_reg <= spp_pkg::ST_IDLE;
          end else begin
            addr_reg <= addr_reg + 4'h1;
            beat_reg <= beat_reg + 2'h1;
            if (cap_last) begin
              st_reg <= spp_pkg::ST_WTAIL;
            end
          end
        end
        spp_pkg::ST_WTAIL: begin
          if (tail_reg == spp_pkg::WR_TAIL_LAST) begin
            st_reg <= spp_pkg::ST_IDLE;
          end else begin
            tail_reg <= tail_reg + 2'h1;
          end
        end
        default: st_reg <= spp_pkg::ST_IDLE;
      endcase
    end
  end

  // Slave FIFO decode; strobes count only under chip select
  spp_pkg::spp_fifo_pins_s fp;
  logic [spp_pkg::THR_W-1:0] sel;
  logic              fifo_act;
  logic              push_any;
  logic              pop_any;
  logic [DW-1:0]     head   [NT];
  logic [spp_pkg::CNT_W-1:0] cnt [NT];
  logic [NT-1:0]     empty;
  logic [NT-1:0]     full;

  assign fp       = fifo_pins_in;
  assign sel      = fp.fifo_select_lines;
  assign fifo_act = !mux_mode && !fp.fifo_chip_select_n;
  assign push_any = fifo_act && !fp.fifo_write_strobe_n;
  assign pop_any  = fifo_act && !fp.fifo_read_strobe_n;

  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_thr
      spp_thread_fifo u_thr (
        .clk_in    (link_clk_in),
        .rst_in    (lrst),
        .push_in   (push_any && sel == t),
        .data_in   (dq_in),
        .pop_in    (pop_any && sel == t),
        .head_out  (head[t]),
        .count_out (cnt[t]),
        .empty_out (empty[t]),
        .full_out  (full[t])
      );
    end
  endgenerate

  // Read pipeline; bus keeps the last word until the next read
  logic [DW-1:0] p1_reg;
  logic          p1v_reg;
  logic [DW-1:0] fifo_dout_reg;
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      p1_reg        <= spp_pkg::DATA_RST;
      p1v_reg       <= 1'b0;
      fifo_dout_reg <= spp_pkg::DATA_RST;
    end else begin
      p1_reg  <= head[sel];
      p1v_reg <= pop_any && !empty[sel];
      if (p1v_reg) begin
        fifo_dout_reg <= p1_reg;
      end
    end
  end

  // Bus drive: FIFO output enable only gates the drivers
  assign dq_out      = mux_mode ? rd_q_reg : fifo_dout_reg;
  assign dq_oe_n_out = mux_mode ? (bus_rel_rd || !(st_reg == spp_pkg::ST_RDATA
                       || st_reg == spp_pkg::ST_RHOLD)) : fp.fifo_output_enable_n;

  // Flag source selection
  function automatic logic flag_eval(input spp_pkg::spp_flag_kind_e k,
                                     input logic e, input logic f,
                                     input logic [spp_pkg::CNT_W-1:0] c);
    case (k)
      spp_pkg::FLAG_FULL:    flag_eval = f;
      spp_pkg::FLAG_PARTIAL: flag_eval = (c >= spp_pkg::PARTIAL_LEVEL);
      default:               flag_eval = e;
    endcase
  endfunction : flag_eval

  logic [spp_pkg::THR_W-1:0] fthr;
  logic flag_now;
  logic flag_p1_reg;
  assign fthr     = cfg_l.flag_dedicated ? cfg_l.flag_thread : sel;
  assign flag_now = flag_eval(cfg_l.flag_kind, empty[fthr], full[fthr], cnt[fthr]);

  // Flag pipeline gives the fixed write and address latency
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      flag_p1_reg <= 1'b0;
      flag_out    <= 1'b0;
    end else begin
      flag_p1_reg <= flag_now;
      flag_out    <= flag_p1_reg;
    end
  end

  // Packet end: short packet with a write, empty packet without
  logic pe;
  logic pe_prev_reg;
  assign pe = fifo_act && !fp.packet_end_n;
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      pe_prev_reg <= 1'b0;
      pkt_tog_reg <= 1'b0;
      zlp_tog_reg <= 1'b0;
    end else begin
      pe_prev_reg <= pe;
      if (pe && !pe_prev_reg && push_any) begin
        pkt_tog_reg <= ~pkt_tog_reg;
      end else if (pe && !pe_prev_reg) begin
        zlp_tog_reg <= ~zlp_tog_reg;
      end
    end
  end

  // Socket switch delay, then thread ready by direction
  logic       sw;
  logic       sw_prev_reg;
  logic [6:0] ssd_cnt_reg;
  logic       sw_done_reg;
  logic [spp_pkg::THR_W-1:0] sw_thr_reg;
  assign sw = !mux_mode && !fp.socket_switch_n;
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      sw_prev_reg <= 1'b0;
      ssd_cnt_reg <= 7'h00;
      sw_done_reg <= 1'b0;
      sw_thr_reg  <= '0;
    end else begin
      sw_prev_reg <= sw;
      if (sw && !sw_prev_reg) begin
        ssd_cnt_reg <= spp_pkg::SSD_CYCLES;
        sw_done_reg <= 1'b0;
        sw_thr_reg  <= sel;
      end else if (ssd_cnt_reg != 7'h00) begin
        ssd_cnt_reg <= ssd_cnt_reg - 7'h01;
        sw_done_reg <= (ssd_cnt_reg == 7'h01);
      end
    end
  end
  assign dma_a_out = sw_done_reg && (cfg_l.producer_mask[sw_thr_reg] ?
                     !full[sw_thr_reg] : !empty[sw_thr_reg]);

  default clocking cb @(posedge link_clk_in); endclocking
  default disable iff (lrst);

  a_read_rdy_lat : assert property (rd_start && !short_lat |-> ##2 rdy_out)
    else $error("read ready not two cycles after enable");
  a_short_lat : assert property (rd_start && short_lat |-> ##1 rdy_out)
    else $error("short latency read ready late");
  a_read_hold : assert property (st_reg == spp_pkg::ST_RHOLD && !bus_rel_rd
    |-> !dq_oe_n_out && $stable(dq_out) && !rdy_out)
    else $error("read data not held with ready low");
  a_burst_run : assert property (st_reg == spp_pkg::ST_RDATA && !rd_last
    && !bus_rel_rd |=> rdy_out)
    else $error("ready dropped inside a burst");
  a_last_drop : assert property (st_reg == spp_pkg::ST_RDATA && rd_last
    && !bus_rel_rd |=> !rdy_out)
    else $error("ready not dropped after last word");
  a_write_tail : assert property (cap_last
    |-> ##1 rdy_out ##1 rdy_out ##1 !rdy_out)
    else $error("write ready not dropped three cycles after last sample");
  a_write_lat : assert property (wr_start && !short_lat |-> ##2 rdy_out)
    else $error("write ready not two cycles after enable");
  a_fifo_rd_lat : assert property (pop_any && !empty[sel]
    |-> ##2 (dq_out == $past(head[sel], 2)))
    else $error("fifo read data not two cycles after strobe");
  a_flag_lat : assert property (push_any |-> ##3 (flag_out == $past(flag_now, 2)))
    else $error("flag not updated three cycles after write");
  a_oe_release : assert property (!mux_mode && fp.fifo_output_enable_n
    |-> dq_oe_n_out)
    else $error("bus driven without fifo output enable");
  a_switch_ready : assert property (sw && !sw_prev_reg && fp.socket_switch_n == 1'b0
    ##1 fp.socket_switch_n |-> ##[1:67] sw_done_reg)
    else $error("socket switch delay out of range");
endmodule : spp_port_top

// ===== hw/spp_sync3.sv
/*
  Three-stage level synchroniser; a change passes once stages two and three agree.
  Assumes each bit is a level or a toggle that is stable for several destination clocks.
*/
`timescale 1ns/1ns
module spp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Capture chain; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    s1_reg <= d_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // Per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule : spp_sync3

// ===== hw/spp_thread_fifo.sv
/*
  One thread buffer of the slave FIFO port: eight words, push and pop per edge.
  Assumes push and pop come from logic on the link clock.
*/
`timescale 1ns/1ns
module spp_thread_fifo (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       push_in,
  input  wire logic [spp_pkg::DATA_W-1:0] data_in,
  input  wire logic                       pop_in,
  output logic      [spp_pkg::DATA_W-1:0] head_out,
  output logic      [spp_pkg::CNT_W-1:0]  count_out,
  output logic                            empty_out,
  output logic                            full_out
);
  localparam int PTR_W = spp_pkg::PTR_W;
  localparam int CNT_W = spp_pkg::CNT_W;

  logic [spp_pkg::DATA_W-1:0] mem [int'(spp_pkg::FIFO_DEPTH)];
  logic [spp_pkg::PTR_W-1:0]  wptr_reg;
  logic [spp_pkg::PTR_W-1:0]  rptr_reg;
  logic [spp_pkg::CNT_W-1:0]  cnt_reg;
  logic                       do_push;
  logic                       do_pop;

  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;
  assign empty_out = (cnt_reg == '0);
  assign full_out  = (cnt_reg == spp_pkg::FIFO_DEPTH);
  assign count_out = cnt_reg;
  assign head_out  = mem[rptr_reg];

  // Store the bus word on each write edge while not full
  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wptr_reg] <= data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      wptr_reg <= wptr_reg + PTR_W'(do_push);
      rptr_reg <= rptr_reg + PTR_W'(do_pop);
      cnt_reg  <= cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  a_push_count : assert property (@(posedge clk_in) disable iff (rst_in)
    (do_push && !do_pop) |=> (cnt_reg == $past(cnt_reg) + 4'h1))
    else $error("write edge did not advance fill count");
endmodule : spp_thread_fifo
